// ===== core/sleep_wakeup_control.v
/*
 Sleep entry and wake-up controller with an AHB-Lite register slave.
 Assumes AHB-Lite single word transfers, hclk at 100 MHz, asynchronous
 active-low hresetn, and that the core runs from core_clk_en.
*/
// How it works
// - Only reset pin, enabled watchdog expiry or enabled wake interrupts end sleep.
// - Reset pin gives full reset; other wake sources resume execution.
// - Power-down flag set at power-up, cleared when sleep executes.
// - Watchdog wake-up clears the expiry flag.
// - Of the peripherals, only async counter timer and RC-clocked conversion may wake.
// - Core phase clocks stop in sleep; other peripherals cannot interrupt.
// - Next sequential instruction is prefetched while sleep executes.
// - Source enable needed to wake; global enable does not matter.
// - Global enable clear: resume after sleep, no vector.
// - Global enable set: run next instruction, then branch to vector.
// - Flag already pending before sleep with global enable clear: sleep is a no-operation.
// - Interrupt during sleep: finish sleep fully, then wake at once.
// - Sleep clears watchdog, clears power-down, sets expiry, holds pins.
`timescale 1ns/1ns
`include "sleep_wakeup_regs.vh"
module sleep_wakeup_control #(
	parameter WDT_WIDTH = 16
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        clk_en,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        master_clear_pin_n,
	input  wire        int_pin,
	input  wire        port_b_change,
	input  wire        async_counter_timer_irq,
	input  wire        adc_done_irq,
	input  wire [12:0] pc_in,
	output wire        core_clk_en,
	output wire        osc_drive_en,
	output wire        pin_hold,
	output wire        prefetch,
	output reg  [12:0] resume_pc,
	output reg         resume_vector,
	output wire        dummy_cycle,
	output wire        device_reset,
	output wire        irq
);
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam ST_RUN   = 3'd0;
	localparam ST_ENTER = 3'd1;
	localparam ST_SLEEP = 3'd2;
	localparam ST_NEXT  = 3'd3;
	localparam ST_DUMMY = 3'd4;

	reg [2:0]  state_reg;
	reg [2:0]  state_next;
	reg [9:0]  ctrl_reg;
	reg        pd_reg;
	reg        to_reg;
	reg [3:0]  ev_reg;
	reg [3:0]  mask_reg;
	reg        dummy_reg;
	reg        wr_pend_reg;
	reg [7:0]  addr_reg;
	reg        sleep_cmd;
	reg        clrwdt_cmd;
	reg [3:0]  ev_set;

	wire [4:0] pins_sync;
	wire       master_clear_pin_n_s;
	wire       int_s;
	wire       portb_s;
	wire       tmr_s;
	wire       adc_s;
	wire       wdt_expired;
	wire       wdt_clear;
	wire       irq_pending;
	wire       addr_phase;
	wire       asleep;
	wire       stat_read;
	wire       ctrl_wr;
	wire       mask_wr;

	// ------------------------------------------------------------
	// Pin synchronisers and watchdog
	// ------------------------------------------------------------
	pin_sync #(
		.WIDTH (5)
	) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.clk_en   (clk_en),
		.async_in ({master_clear_pin_n, int_pin, port_b_change,
			async_counter_timer_irq, adc_done_irq}),
		.sync_out (pins_sync)
	);

	assign master_clear_pin_n_s = pins_sync[4];
	assign int_s    = pins_sync[3];
	assign portb_s  = pins_sync[2];
	assign tmr_s    = pins_sync[1];
	assign adc_s    = pins_sync[0];

	assign wdt_clear = clrwdt_cmd || (state_reg == ST_ENTER);

	watchdog_counter #(
		.WIDTH  (WDT_WIDTH),
		.PERIOD (`WDT_PERIOD)
	) u_wdt (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.enable  (ctrl_reg[`CTRL_WDT_EN]),
		.clear   (wdt_clear),
		.expired (wdt_expired),
		.count   ()
	);

	assign irq_pending = (int_s && ctrl_reg[`CTRL_INT_EN])
		|| (portb_s && ctrl_reg[`CTRL_PORTB_EN])
		|| (tmr_s && ctrl_reg[`CTRL_TMR_EN] && ctrl_reg[`CTRL_TMR_ASYNC])
		|| (adc_s && ctrl_reg[`CTRL_ADC_EN] && ctrl_reg[`CTRL_ADC_RC]);

	// ------------------------------------------------------------
	// Core facing outputs
	// ------------------------------------------------------------
	assign asleep       = (state_reg == ST_SLEEP);
	assign core_clk_en  = !asleep;
	assign osc_drive_en = !asleep;
	assign pin_hold     = asleep;
	assign prefetch     = (state_reg == ST_ENTER);
	assign dummy_cycle  = dummy_reg;
	assign device_reset = !master_clear_pin_n_s;

	// ------------------------------------------------------------
	// Sleep state machine
	// ------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				// pending flag makes sleep a no-op when global enable clear
				if (sleep_cmd && !(irq_pending && !ctrl_reg[`CTRL_GIE]))
					state_next = ST_ENTER;
			end
			ST_ENTER: begin
				state_next = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (irq_pending || wdt_expired)
					state_next = ST_NEXT;
			end
			ST_NEXT: begin
				if (resume_vector)
					state_next = ST_DUMMY;
				else
					state_next = ST_RUN;
			end
			ST_DUMMY: begin
				if (dummy_reg)
					state_next = ST_RUN;
			end
			default: state_next = ST_RUN;
		endcase
	end

	// Event sources for the sticky status
	always @* begin
		ev_set = 4'h0;
		ev_set[`EV_WAKE_IRQ]  = asleep && irq_pending;
		ev_set[`EV_WAKE_WDT]  = asleep && wdt_expired && !irq_pending;
		ev_set[`EV_SLEEP_NOP] = (state_reg == ST_RUN) && sleep_cmd
			&& irq_pending && !ctrl_reg[`CTRL_GIE];
		ev_set[`EV_SLEEP_IN]  = (state_reg == ST_ENTER);
	end

	// State, flags and resume target
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg     <= ST_RUN;
			pd_reg        <= 1'b1;
			to_reg        <= 1'b1;
			resume_pc     <= 13'h0000;
			resume_vector <= 1'b0;
			dummy_reg     <= 1'b0;
		end else if (clk_en) begin
			if (!master_clear_pin_n_s) begin
				state_reg     <= ST_RUN;
				pd_reg        <= 1'b1;
				to_reg        <= 1'b1;
				resume_vector <= 1'b0;
				dummy_reg     <= 1'b0;
			end else begin
				state_reg <= state_next;
				if (state_reg == ST_ENTER) begin
					pd_reg    <= 1'b0;
					to_reg    <= 1'b1;
					resume_pc <= pc_in + 13'h0001;
				end
				if (asleep && wdt_expired && !irq_pending)
					// expiry flag cleared on watchdog wake
					to_reg <= 1'b0;
				if (asleep && (irq_pending || wdt_expired)) begin
					// no vector when global enable clear
					resume_vector <= irq_pending && ctrl_reg[`CTRL_GIE];
				end
				if (state_reg == ST_NEXT && resume_vector)
					dummy_reg <= 1'b1;
				else if (state_reg == ST_DUMMY && dummy_reg)
					dummy_reg <= 1'b0;
				if (state_reg == ST_DUMMY && dummy_reg) begin
					resume_pc     <= `VECTOR_ADDR;
					resume_vector <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------
	assign addr_phase = hsel && hready && htrans[1];
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	// Events are cleared as the status read is taken, so none set later is lost
	assign stat_read  = addr_phase && !hwrite && (haddr == `OFS_IRQ_STAT);
	assign ctrl_wr    = wr_pend_reg && (addr_reg == `OFS_CTRL);
	assign mask_wr    = wr_pend_reg && (addr_reg == `OFS_IRQ_MASK);
	assign irq        = |(ev_reg & mask_reg);

	// Address phase capture and write data
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
			ctrl_reg    <= `CTRL_RESET;
			mask_reg    <= 4'h0;
			sleep_cmd   <= 1'b0;
			clrwdt_cmd  <= 1'b0;
		end else if (clk_en) begin
			wr_pend_reg <= addr_phase && hwrite;
			if (addr_phase)
				addr_reg <= haddr;
			sleep_cmd  <= 1'b0;
			clrwdt_cmd <= 1'b0;
			if (wr_pend_reg) begin
				case (addr_reg)
					`OFS_CTRL: begin
						ctrl_reg   <= hwdata[9:0] & 10'h3FC;
						sleep_cmd  <= hwdata[`CTRL_SLEEP];
						clrwdt_cmd <= hwdata[`CTRL_CLRWDT];
					end
					`OFS_IRQ_MASK: mask_reg <= hwdata[3:0];
					default: ;
				endcase
			end
		end
	end

	// Sticky events; a set wins over the clear by read
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_reg <= 4'h0;
		end else if (clk_en) begin
			ev_reg <= (stat_read ? 4'h0 : ev_reg) | ev_set;
		end
	end

	// Read data registered in the address phase, zero outside the data phase;
	// a write still in its data phase is passed on to a read right behind it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en) begin
			hrdata <= 32'h0000_0000;
			if (addr_phase && !hwrite) begin
				case (haddr)
					`OFS_CTRL:     hrdata <= {22'h0, ctrl_wr ? (hwdata[9:0] & 10'h3FC) : ctrl_reg};
					`OFS_STATUS:   hrdata <= {25'h0, state_reg, 1'b0, asleep, to_reg, pd_reg};
					`OFS_IRQ_STAT: hrdata <= {28'h0, ev_reg};
					`OFS_IRQ_MASK: hrdata <= {28'h0, mask_wr ? hwdata[3:0] : mask_reg};
					`OFS_RESUME:   hrdata <= {18'h0, resume_vector, resume_pc};
					default:       hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// ===== core/sleep_wakeup_regs.vh
/*
 Register offsets, field positions, reset values and timing counts of the
 sleep and wake-up controller.
 Assumes inclusion by bare name from the design files of core/.
*/
`ifndef SLEEP_WAKEUP_REGS_VH
`define SLEEP_WAKEUP_REGS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_IRQ_STAT  8'h08
`define OFS_IRQ_MASK  8'h0C
`define OFS_RESUME    8'h10

// ------------------------------------------------------------
// Control register fields (write)
// ------------------------------------------------------------
`define CTRL_SLEEP     0
`define CTRL_CLRWDT    1
`define CTRL_GIE       2
`define CTRL_WDT_EN    3
`define CTRL_INT_EN    4
`define CTRL_PORTB_EN  5
`define CTRL_TMR_EN    6
`define CTRL_ADC_EN    7
`define CTRL_ADC_RC    8
`define CTRL_TMR_ASYNC 9
`define CTRL_RESET     10'h000

// ------------------------------------------------------------
// Status register fields (read)
// ------------------------------------------------------------
`define ST_PD          0
`define ST_TO          1
`define ST_ASLEEP      2
`define ST_STATE_LSB   4

// ------------------------------------------------------------
// Event bits of interrupt status and mask
// ------------------------------------------------------------
`define EV_WAKE_IRQ    0
`define EV_WAKE_WDT    1
`define EV_SLEEP_NOP   2
`define EV_SLEEP_IN    3
`define EV_WIDTH       4

// ------------------------------------------------------------
// Resume and timing
// ------------------------------------------------------------
`define VECTOR_ADDR    13'h0004
`define DUMMY_CYCLES   2
`define WDT_PERIOD     16'hFFFF

`endif

// ===== core/pin_sync.v
/*
 Two-flop synchroniser bank for asynchronous pin inputs.
 Assumes one clock, asynchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ns
module pin_sync #(
	parameter WIDTH = 1
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             clk_en,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// Two stages; only the second stage is read outside
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

// ===== core/watchdog_counter.v
/*
 Watchdog counter that keeps running in sleep and pulses on expiry.
 Assumes one clock domain; clear and enable come from the same clock.
*/
`timescale 1ns/1ns
`include "sleep_wakeup_regs.vh"
module watchdog_counter #(
	parameter        WIDTH  = 16,
	parameter [15:0] PERIOD = `WDT_PERIOD
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             clk_en,
	input  wire             enable,
	input  wire             clear,
	output reg              expired,
	output wire [WIDTH-1:0] count
);
	reg [WIDTH-1:0] count_reg;

	// Count up, wrap and pulse when the period is reached
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= {WIDTH{1'b0}};
			expired   <= 1'b0;
		end else if (clk_en) begin
			expired <= 1'b0;
			if (clear || !enable) begin
				count_reg <= {WIDTH{1'b0}};
			end else if (count_reg == PERIOD[WIDTH-1:0]) begin
				count_reg <= {WIDTH{1'b0}};
				expired   <= 1'b1;
			end else begin
				count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	assign count = count_reg;
endmodule

// ===== tb/sleep_wakeup_control_chk.sv
/*
 Port checker of the sleep and wake-up controller.
 Assumes clk_en held high; bound to the top module.
*/
`timescale 1ns/1ns
module sleep_wakeup_control_chk (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	input wire        master_clear_pin_n,
	input wire        core_clk_en,
	input wire        osc_drive_en,
	input wire        pin_hold,
	input wire        prefetch,
	input wire [12:0] resume_pc,
	input wire        resume_vector,
	input wire        dummy_cycle,
	input wire        device_reset
);
// --------------------------------
// Helpers
// --------------------------------
reg rd_ph;
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
// Read data phase tracker
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn)
		rd_ph <= 1'b0;
	else
		rd_ph <= hsel && hready && htrans[1] && !hwrite;
end
sequence vec_seq;
	resume_vector ##[0:2] (resume_pc == 13'h0004);
endsequence
// --------------------------------
// Assertions
// --------------------------------
ahb_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
rdata_idle_a: assert property (!rd_ph |-> hrdata == 32'h0) else $error("read data outside phase");
sleep_out_a: assert property (!core_clk_en |-> !osc_drive_en && pin_hold) else $error("sleep outputs");
run_out_a: assert property (core_clk_en |-> osc_drive_en && !pin_hold) else $error("run outputs");
sleep_entry_a: assert property ($fell(core_clk_en) |-> $past(prefetch)) else $error("no prefetch");
prefetch_pulse_a: assert property (prefetch |=> !prefetch) else $error("long prefetch");
dummy_vec_a: assert property (dummy_cycle |-> vec_seq) else $error("dummy without vector");
dummy_pulse_a: assert property (dummy_cycle |=> !dummy_cycle) else $error("long dummy");
clear_reset_a: assert property ($fell(master_clear_pin_n) |-> ##[1:3] device_reset)
	else $error("pin reset missed");
reset_run_a: assert property (device_reset |=> core_clk_en) else $error("asleep in reset");
endmodule
bind sleep_wakeup_control sleep_wakeup_control_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .master_clear_pin_n(master_clear_pin_n), .core_clk_en(core_clk_en),
	.osc_drive_en(osc_drive_en), .pin_hold(pin_hold), .prefetch(prefetch), .resume_pc(resume_pc),
	.resume_vector(resume_vector), .dummy_cycle(dummy_cycle), .device_reset(device_reset));

// ===== tb/sleep_wakeup_control_tb.sv
/*
 Self-checking bench of the sleep and wake-up controller.
 Assumes the AHB-Lite slave answers with no wait states.
*/
`timescale 1ns/1ns
module sleep_wakeup_control_tb;
reg         hclk = 1'b0;
reg         hresetn = 1'b0;
reg         hsel = 1'b0;
reg  [7:0]  haddr = 8'h00;
reg  [1:0]  htrans = 2'h0;
reg         hwrite = 1'b0;
reg  [31:0] hwdata = 32'h0;
reg         master_clear_pin_n = 1'b1;
reg  [3:0]  src = 4'h0;
reg  [12:0] pc_in = 13'h0123;
reg  [31:0] rdv;
integer     failures = 0;
integer     num_checks = 0;
wire        hreadyout, hresp, core_clk_en, resume_vector, dummy_cycle, irq;
wire [31:0] hrdata;
wire [12:0] resume_pc;
// --------------------------------
// Clock and design
// --------------------------------
always #5 hclk = ~hclk;
sleep_wakeup_control #(.WDT_WIDTH(4)) u_sleep_wakeup_control (.hclk(hclk), .hresetn(hresetn),
	.clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
	.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.master_clear_pin_n(master_clear_pin_n), .int_pin(src[0]), .port_b_change(src[1]),
	.async_counter_timer_irq(src[2]), .adc_done_irq(src[3]), .pc_in(pc_in),
	.core_clk_en(core_clk_en), .osc_drive_en(), .pin_hold(), .prefetch(), .resume_pc(resume_pc),
	.resume_vector(resume_vector), .dummy_cycle(dummy_cycle), .device_reset(), .irq(irq));
// --------------------------------
// Shared tasks
// --------------------------------
task chk(input string nm, input [31:0] exp, input [31:0] got);
	begin
		num_checks = num_checks + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	end
endtask
// One single AHB transfer
task ahb(input w, input [7:0] a, input [31:0] wd);
	begin
		@(posedge hclk);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	end
endtask
task master_clear_pin;
	begin
		@(posedge hclk);
		master_clear_pin_n <= 1'b0;
		repeat (4) @(posedge hclk);
		master_clear_pin_n <= 1'b1;
		repeat (4) @(posedge hclk);
		ahb(0, 8'h04, 0);
		chk("status after pin reset", 2'h3, rdv[1:0]);
	end
endtask
// Sleep, raise sources, judge the wake-up
task nap(input [9:0] ctrl, input [3:0] s, input wake, input vec, input [1:0] st);
	integer i, nd;
	reg     rv;
	begin
		ahb(1, 8'h00, {22'h0, ctrl} | 32'h1);
		i = 0;
		while (core_clk_en !== 1'b0 && i < 20) begin @(negedge hclk); i = i + 1; end
		chk("asleep", 0, core_clk_en);
		@(posedge hclk);
		src <= s;
		i = 0;
		while (core_clk_en !== 1'b1 && i < 300) begin @(negedge hclk); i = i + 1; end
		chk("woken", wake, core_clk_en);
		// Vector flag stands only until the branch is taken
		rv = resume_vector;
		nd = 0;
		repeat (8) begin @(negedge hclk); if (dummy_cycle === 1'b1) nd = nd + 1; end
		@(posedge hclk);
		src <= 4'h0;
		if (wake) begin
			chk("vector", vec, rv);
			chk("resume pc", vec ? 13'h0004 : 13'h0124, resume_pc);
			chk("dummy count", vec, nd);
		end
		ahb(0, 8'h04, 0);
		chk("status flags", st, rdv[1:0]);
	end
endtask
// --------------------------------
// Scenarios
// --------------------------------
task t_reset;
	begin
		ahb(0, 8'h04, 0);
		chk("status at power-up", 2'h3, rdv[1:0]);
		ahb(1, 8'h20, 32'hFFFFFFFF);
		ahb(0, 8'h20, 0);
		chk("unmapped read", 0, rdv);
		$display("t_reset done");
	end
endtask
task t_irq;
	begin
		nap(10'h010, 4'h1, 1, 0, 2'h2); master_clear_pin;
		nap(10'h014, 4'h1, 1, 1, 2'h2); master_clear_pin;
		nap(10'h004, 4'h1, 0, 0, 2'h2); master_clear_pin;
		$display("t_irq done");
	end
endtask
task t_periph;
	begin
		nap(10'h020, 4'h2, 1, 0, 2'h2); master_clear_pin;
		nap(10'h240, 4'h4, 1, 0, 2'h2); master_clear_pin;
		nap(10'h040, 4'h4, 0, 0, 2'h2); master_clear_pin;
		nap(10'h180, 4'h8, 1, 0, 2'h2); master_clear_pin;
		nap(10'h080, 4'h8, 0, 0, 2'h2); master_clear_pin;
		$display("t_periph done");
	end
endtask
task t_wdt;
	begin
		chk("masked irq", 0, irq);
		ahb(0, 8'h08, 0);
		ahb(1, 8'h0C, 32'h2);
		nap(10'h008, 4'h0, 1, 0, 2'h0);
		chk("irq raised", 1, irq);
		ahb(0, 8'h08, 0);
		chk("wake events", 32'hA, rdv & 32'hA);
		@(negedge hclk);
		chk("irq cleared", 0, irq);
		master_clear_pin;
		$display("t_wdt done");
	end
endtask
task t_nop;
	integer lows;
	begin
		ahb(0, 8'h08, 0);
		src <= 4'h1;
		ahb(1, 8'h00, 32'h10);
		repeat (6) @(posedge hclk);
		ahb(1, 8'h00, 32'h11);
		lows = 0;
		repeat (20) begin @(negedge hclk); if (core_clk_en !== 1'b1) lows = lows + 1; end
		chk("no sleep", 0, lows);
		ahb(0, 8'h04, 0);
		chk("flags kept", 2'h3, rdv[1:0]);
		ahb(0, 8'h08, 0);
		chk("nop event", 1, rdv[2]);
		src <= 4'h0;
		$display("t_nop done");
	end
endtask
task results;
	begin
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
endtask
// Watchdog against a hang
initial begin
	#300000;
	failures = failures + 1;
	results;
end
// Main sequence
initial begin
	repeat (5) @(posedge hclk);
	hresetn <= 1'b1;
	t_reset;
	t_irq;
	t_periph;
	t_wdt;
	t_nop;
	results;
end
endmodule
